// >>> design/system_reset_sequencer.sv
// Top of the reset sequencer: source gathering, power-on count and release
`timescale 1ns/1ps
`default_nettype none
module system_reset_sequencer #(
  parameter int unsigned POR_COUNT_CYCLES = rst_seq_pkg::POR_CYCLES,
  parameter int unsigned PIN_MIN_CYCLES = rst_seq_pkg::PIN_LOW_MIN_CYCLES
) (
  input wire logic REF_CLK_IN,
  input wire logic RST_B_IN,
  input wire logic CLK_EN_IN,
  input wire logic POR_RELEASE_IN,
  input wire logic VOLTAGE_DROP_DETECTOR_IN,
  input wire logic RESET_PIN_B_IN,
  input wire logic WATCHDOG_TIMER_IN,
  input wire logic OSC_FREQUENCY_DETECTOR_IN,
  input wire logic SOFTWARE_RESET_REQUEST_IN,
  input wire logic XOSC_ENABLE_REQ_IN,
  input wire logic PLL_ENABLE_REQ_IN,
  input wire logic FLAGS_CLEAR_IN,
  input wire logic FLASH_SEC_WRITE_IN,
  input wire logic FLASH_SEC_DATA_IN,
  output logic SYS_RESET_B_OUT,
  output logic COLD_RESET_B_OUT,
  output logic IOSC_ENABLE_OUT,
  output logic XOSC_ENABLE_OUT,
  output logic PLL_ENABLE_OUT,
  output rst_seq_pkg::reset_sources_t RESET_SOURCE_FLAGS_OUT,
  output logic FLASH_SECURITY_BIT_REG_OUT
);
  import rst_seq_pkg::*;

  localparam int unsigned CNT_W = $clog2(POR_COUNT_CYCLES + 1);
  localparam logic [CNT_W-1:0] POR_LAST = CNT_W'(POR_COUNT_CYCLES - 1);

  seq_state_t state;
  seq_state_t next_state;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic pin_qualified;
  reset_sources_t sources;
  logic flag_set;
  reset_sources_t flag_value;
  logic sec_write;
  logic next_sys_reset_b;
  logic next_cold_reset_b;
  logic next_iosc;
  logic next_xosc;
  logic next_pll;

  // The core fault lock output has no input here: core_fault_lock is left to NMI or a
  // reset, never turned into a reset by this block.
  always_comb begin
    sources = '0;
    sources.voltage_drop = VOLTAGE_DROP_DETECTOR_IN;
    sources.watchdog = WATCHDOG_TIMER_IN;
    sources.osc_freq = OSC_FREQUENCY_DETECTOR_IN;
    sources.software = SOFTWARE_RESET_REQUEST_IN;
    sources.pin = pin_qualified;
    sources.por = !POR_RELEASE_IN;
  end

  low_width_qualifier #(
    .MIN_CYCLES(PIN_MIN_CYCLES)
  ) u_pin_qual (
    .clk_in(REF_CLK_IN),
    .rst_b_in(RST_B_IN),
    .en_in(CLK_EN_IN),
    .pin_b_in(RESET_PIN_B_IN),
    .qualified_out(pin_qualified)
  );

  // Sequencer: cold phases first, then run, warm hold or pin hold
  always_comb begin
    next_state = state;
    next_count = count;
    flag_set = 1'b0;
    flag_value = '0;
    case (state)
      ST_POWER_ON: begin
        next_count = '0;
        if (POR_RELEASE_IN) begin
          next_state = ST_POR_COUNT;
        end
      end
      ST_POR_COUNT: begin
        // The pin is looked at only on the last count, so a pin that rises during the count
        // gives exactly the plain power-on sequence.
        if (!POR_RELEASE_IN) begin
          next_state = ST_POWER_ON;
        end else if (count == POR_LAST) begin
          flag_set = 1'b1;
          flag_value.por = 1'b1;
          next_state = pin_qualified ? ST_PIN_HOLD : ST_RUN;
        end else begin
          next_count = count + CNT_W'(1);
        end
      end
      ST_RUN: begin
        if (!POR_RELEASE_IN) begin
          next_state = ST_POWER_ON;
        end else if (pin_qualified) begin
          flag_set = 1'b1;
          flag_value.pin = 1'b1;
          next_state = ST_PIN_HOLD;
        end else if (any_warm(sources)) begin
          flag_set = 1'b1;
          flag_value = sources;
          next_state = ST_WARM;
        end
      end
      ST_WARM: begin
        if (!POR_RELEASE_IN) begin
          next_state = ST_POWER_ON;
        end else if (pin_qualified) begin
          next_state = ST_PIN_HOLD;
        end else if (!any_warm(sources)) begin
          next_state = ST_RUN;
        end
      end
      ST_PIN_HOLD: begin
        if (!POR_RELEASE_IN) begin
          next_state = ST_POWER_ON;
        end else if (RESET_PIN_B_IN) begin
          next_state = any_warm(sources) ? ST_WARM : ST_RUN;
        end
      end
      default: begin
        next_state = ST_POWER_ON;
        next_count = '0;
      end
    endcase
  end

  always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      state <= ST_POWER_ON;
      count <= '0;
    end else if (CLK_EN_IN) begin
      state <= next_state;
      count <= next_count;
    end
  end

  // Flash security bit may only be written while the system runs undisturbed
  assign sec_write = FLASH_SEC_WRITE_IN && (state == ST_RUN) && (next_state == ST_RUN);

  cold_domain_store u_cold (
    .clk_in(REF_CLK_IN),
    .rst_b_in(RST_B_IN),
    .en_in(CLK_EN_IN),
    .cold_init_in(state == ST_POWER_ON),
    .flag_set_in(flag_set),
    .flag_value_in(flag_value),
    .flag_clear_in(FLAGS_CLEAR_IN),
    .sec_write_in(sec_write),
    .sec_data_in(FLASH_SEC_DATA_IN),
    .flags_out(RESET_SOURCE_FLAGS_OUT),
    .sec_bit_out(FLASH_SECURITY_BIT_REG_OUT)
  );

  // Outputs are registered from the next state so they move with it
  always_comb begin
    next_sys_reset_b = (next_state == ST_RUN);
    next_cold_reset_b = !is_cold(next_state);
    // Nothing here asks RAM to be retained; its contents are lost.
    next_iosc = 1'b1;
    next_xosc = (next_state == ST_RUN) && XOSC_ENABLE_REQ_IN;
    next_pll = (next_state == ST_RUN) && PLL_ENABLE_REQ_IN;
  end

  always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      SYS_RESET_B_OUT <= 1'b0;
      COLD_RESET_B_OUT <= 1'b0;
      IOSC_ENABLE_OUT <= 1'b1;
      XOSC_ENABLE_OUT <= 1'b0;
      PLL_ENABLE_OUT <= 1'b0;
    end else if (CLK_EN_IN) begin
      SYS_RESET_B_OUT <= next_sys_reset_b;
      COLD_RESET_B_OUT <= next_cold_reset_b;
      IOSC_ENABLE_OUT <= next_iosc;
      XOSC_ENABLE_OUT <= next_xosc;
      PLL_ENABLE_OUT <= next_pll;
    end
  end

  default clocking cb @(posedge REF_CLK_IN);
  endclocking
  default disable iff (!RST_B_IN);

  sequence s_running_no_pin;
    CLK_EN_IN && state == ST_RUN && POR_RELEASE_IN && !pin_qualified;
  endsequence

  sequence s_count_done;
    CLK_EN_IN && state == ST_POR_COUNT && POR_RELEASE_IN && count == POR_LAST;
  endsequence

  sequence s_running_quiet;
    s_running_no_pin ##0 !any_warm(sources);
  endsequence

  AST_SOURCE_ASSERTS_RESET: assert property (
    s_running_no_pin ##0 any_warm(sources) |=> !SYS_RESET_B_OUT && state == ST_WARM)
    else $error("warm source did not assert reset");

  AST_SOFTWARE_REQUEST: assert property (
    s_running_no_pin ##0 SOFTWARE_RESET_REQUEST_IN |=> !SYS_RESET_B_OUT ##0 RESET_SOURCE_FLAGS_OUT.software)
    else $error("software request not taken as reset");

  AST_POR_RELEASE: assert property (
    s_count_done ##0 !pin_qualified |=> SYS_RESET_B_OUT && COLD_RESET_B_OUT)
    else $error("reset not released at end of power-on count");

  AST_POR_HOLD: assert property (
    state == ST_POR_COUNT |-> !SYS_RESET_B_OUT && !COLD_RESET_B_OUT)
    else $error("reset released during power-on count");

  AST_PIN_IGNORED_IN_COUNT: assert property (
    CLK_EN_IN && state == ST_POR_COUNT && POR_RELEASE_IN && count != POR_LAST
      |=> state == ST_POR_COUNT && count == $past(count) + CNT_W'(1))
    else $error("power-on count disturbed");

  AST_PIN_RELEASE: assert property (
    CLK_EN_IN && state == ST_PIN_HOLD && POR_RELEASE_IN && RESET_PIN_B_IN && !any_warm(sources)
      |=> SYS_RESET_B_OUT)
    else $error("reset not released after pin went high");

  AST_PIN_HOLDS: assert property (
    CLK_EN_IN && state == ST_PIN_HOLD && !RESET_PIN_B_IN |=> !SYS_RESET_B_OUT [*1])
    else $error("reset released while pin low");

  AST_RESET_MATCHES_STATE: assert property (
    SYS_RESET_B_OUT == (state == ST_RUN) && (COLD_RESET_B_OUT || !SYS_RESET_B_OUT))
    else $error("system reset output out of step");

  AST_COLD_ONLY_STORE: assert property (
    state == ST_WARM || state == ST_PIN_HOLD |=> $stable(FLASH_SECURITY_BIT_REG_OUT))
    else $error("flash security bit changed in warm reset");

  AST_COLD_CLEARS: assert property (
    CLK_EN_IN && state == ST_POWER_ON |=> RESET_SOURCE_FLAGS_OUT == FLAGS_RESET
      && FLASH_SECURITY_BIT_REG_OUT == FLASH_SEC_RESET)
    else $error("cold reset did not initialise the cold store");

  AST_CLOCKS_AFTER_RESET: assert property (
    !SYS_RESET_B_OUT |-> IOSC_ENABLE_OUT && !XOSC_ENABLE_OUT && !PLL_ENABLE_OUT)
    else $error("oscillator setup wrong while in reset");

  AST_FLAG_RECORDED: assert property (
    s_running_no_pin ##0 WATCHDOG_TIMER_IN |=> RESET_SOURCE_FLAGS_OUT.watchdog)
    else $error("watchdog cause not recorded");

  AST_POWER_LOSS_COLD: assert property (
    CLK_EN_IN && !POR_RELEASE_IN |=> state == ST_POWER_ON && !SYS_RESET_B_OUT && !COLD_RESET_B_OUT)
    else $error("supply loss did not give a cold reset");

  AST_COUNT_STARTS: assert property (
    CLK_EN_IN && state == ST_POWER_ON && POR_RELEASE_IN |=> state == ST_POR_COUNT && count == '0)
    else $error("power-on count did not start from zero");

  AST_PIN_PRIORITY: assert property (
    CLK_EN_IN && state == ST_RUN && POR_RELEASE_IN && pin_qualified
      |=> state == ST_PIN_HOLD && !SYS_RESET_B_OUT && RESET_SOURCE_FLAGS_OUT.pin)
    else $error("qualified pin did not start a pin reset");

  AST_WARM_HOLDS: assert property (
    CLK_EN_IN && state == ST_WARM && POR_RELEASE_IN && !pin_qualified && any_warm(sources)
      |=> state == ST_WARM && !SYS_RESET_B_OUT)
    else $error("warm reset ended while a source was still high");

  AST_WARM_RELEASE: assert property (
    CLK_EN_IN && state == ST_WARM && POR_RELEASE_IN && !pin_qualified && !any_warm(sources)
      |=> SYS_RESET_B_OUT)
    else $error("warm reset not released after sources went low");

  AST_HOLD_KEEPS_COLD: assert property (
    state == ST_WARM || state == ST_PIN_HOLD |-> COLD_RESET_B_OUT)
    else $error("cold reset asserted during a warm reset");

  AST_FLAGS_KEPT_IN_HOLD: assert property (
    CLK_EN_IN && (state == ST_WARM || state == ST_PIN_HOLD) && !FLAGS_CLEAR_IN
      |=> $stable(RESET_SOURCE_FLAGS_OUT))
    else $error("source flags changed while reset was held");

  AST_IOSC_ON: assert property (
    IOSC_ENABLE_OUT)
    else $error("internal oscillator disabled");

  AST_OSC_FOLLOWS_REQ: assert property (
    s_running_quiet |=> XOSC_ENABLE_OUT == $past(XOSC_ENABLE_REQ_IN)
      && PLL_ENABLE_OUT == $past(PLL_ENABLE_REQ_IN))
    else $error("oscillator enables do not follow the software request");

  AST_SEC_WRITE_TAKEN: assert property (
    s_running_quiet ##0 FLASH_SEC_WRITE_IN |=> FLASH_SECURITY_BIT_REG_OUT == $past(FLASH_SEC_DATA_IN))
    else $error("security bit write in run was lost");

  AST_SEC_WRITE_REFUSED: assert property (
    CLK_EN_IN && state != ST_RUN && state != ST_POWER_ON |=> $stable(FLASH_SECURITY_BIT_REG_OUT))
    else $error("security bit changed outside run");

  AST_FREEZE: assert property (
    !CLK_EN_IN |=> $stable(state) && $stable(SYS_RESET_B_OUT) && $stable(RESET_SOURCE_FLAGS_OUT))
    else $error("state moved while the clock enable was low");

endmodule : system_reset_sequencer
`default_nettype wire

// >>> design/rst_seq_pkg.sv
// Constants, types and helpers shared by the reset sequencer files
// Summary of operation
// - Internal reset comes from power-on, voltage drop, pin, watchdog, frequency detector, software.
// - After supply passes release level, hold reset about 3.2 ms by counter.
// - The reset pin has no effect until the power-on counter has finished.
// - Pin released within 3.2 ms of power-on gives a plain power-on sequence.
// - After a qualified pin reset, internal reset releases once the pin is high.
// - Every reset returns core and peripheral control registers to initial values.
// - Debug units, source flags and flash security bit reset only on cold reset.
// - After release run on internal oscillator; external oscillator and PLL stay off unless software requests them.
// - The core's software reset request acts as a system reset source.
// - The core fault lock output is left unconnected; NMI or reset leaves it.
// - Internal RAM contents are not kept across any reset.
package rst_seq_pkg;

  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned POR_TIME_NS = 3_200_000;
  localparam int unsigned POR_CYCLES = POR_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned IOSC_PERIOD_NS = 100;
  localparam int unsigned PIN_LOW_MIN_CLOCKS = 12;
  localparam int unsigned PIN_LOW_MIN_CYCLES =
    (PIN_LOW_MIN_CLOCKS * IOSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Bit positions of the reset source flags
  localparam int unsigned FLAG_POS_POR = 5;
  localparam int unsigned FLAG_POS_VOLTAGE_DROP = 4;
  localparam int unsigned FLAG_POS_PIN = 3;
  localparam int unsigned FLAG_POS_WATCHDOG = 2;
  localparam int unsigned FLAG_POS_OSC_FREQ = 1;
  localparam int unsigned FLAG_POS_SOFTWARE = 0;
  localparam logic [5:0] FLAGS_RESET = 6'h00;
  localparam logic FLASH_SEC_RESET = 1'h0;

  typedef struct packed {
    logic por;
    logic voltage_drop;
    logic pin;
    logic watchdog;
    logic osc_freq;
    logic software;
  } reset_sources_t;

  typedef enum logic [4:0] {
    ST_POWER_ON = 5'h01,
    ST_POR_COUNT = 5'h02,
    ST_RUN = 5'h04,
    ST_WARM = 5'h08,
    ST_PIN_HOLD = 5'h10
  } seq_state_t;

  function automatic logic any_warm(input reset_sources_t s);
    return s.voltage_drop | s.watchdog | s.osc_freq | s.software;
  endfunction : any_warm

  function automatic logic is_cold(input seq_state_t s);
    return (s == ST_POWER_ON) || (s == ST_POR_COUNT);
  endfunction : is_cold

endpackage : rst_seq_pkg

// >>> design/low_width_qualifier.sv
// Qualifies an active-low pin that must stay low for a least number of cycles
`timescale 1ns/1ps
`default_nettype none
module low_width_qualifier #(
  parameter int unsigned MIN_CYCLES = rst_seq_pkg::PIN_LOW_MIN_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic en_in,
  input wire logic pin_b_in,
  output logic qualified_out
);
  import rst_seq_pkg::*;

  localparam int unsigned CNT_W = $clog2(MIN_CYCLES + 1);
  localparam logic [CNT_W-1:0] LAST = CNT_W'(MIN_CYCLES - 1);

  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic next_qualified;

  // A short glitch restarts the count, so only a full-width low resets
  always_comb begin
    next_count = count;
    next_qualified = qualified_out;
    if (pin_b_in) begin
      next_count = '0;
      next_qualified = 1'b0;
    end else if (count == LAST) begin
      next_qualified = 1'b1;
    end else begin
      next_count = count + CNT_W'(1);
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      count <= '0;
      qualified_out <= 1'b0;
    end else if (en_in) begin
      count <= next_count;
      qualified_out <= next_qualified;
    end
  end

  AST_PIN_QUALIFY_AT_MIN: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    en_in && !pin_b_in && count == LAST |=> qualified_out)
    else $error("pin low for the minimum width was not qualified");

  AST_PIN_HIGH_DROPS: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    en_in && pin_b_in |=> !qualified_out && count == '0)
    else $error("pin high did not drop qualification");

endmodule : low_width_qualifier
`default_nettype wire

// >>> design/cold_domain_store.sv
// Registers that keep their contents through warm resets
`timescale 1ns/1ps
`default_nettype none
module cold_domain_store (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic en_in,
  input wire logic cold_init_in,
  input wire logic flag_set_in,
  input wire rst_seq_pkg::reset_sources_t flag_value_in,
  input wire logic flag_clear_in,
  input wire logic sec_write_in,
  input wire logic sec_data_in,
  output rst_seq_pkg::reset_sources_t flags_out,
  output logic sec_bit_out
);
  import rst_seq_pkg::*;

  reset_sources_t next_flags;
  logic next_sec_bit;

  // A new cause wins over a software clear in the same cycle
  always_comb begin
    next_flags = flags_out;
    next_sec_bit = sec_bit_out;
    if (cold_init_in) begin
      next_flags = reset_sources_t'(FLAGS_RESET);
      next_sec_bit = FLASH_SEC_RESET;
    end else begin
      if (flag_set_in) begin
        next_flags = flag_value_in;
      end else if (flag_clear_in) begin
        next_flags = reset_sources_t'(FLAGS_RESET);
      end
      if (sec_write_in) begin
        next_sec_bit = sec_data_in;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      flags_out <= reset_sources_t'(FLAGS_RESET);
      sec_bit_out <= FLASH_SEC_RESET;
    end else if (en_in) begin
      flags_out <= next_flags;
      sec_bit_out <= next_sec_bit;
    end
  end

endmodule : cold_domain_store
`default_nettype wire

// >>> verification/supply_pin_model.sv
// Model of the supply monitor and of the party that drives the reset pin
`timescale 1ns/1ps
`default_nettype none
module supply_pin_model (
  input wire logic clk_in,
  input wire logic supply_on_in,
  input wire logic pulse_in,
  input wire logic [7:0] low_len_in,
  output logic por_release_out,
  output logic pin_b_out
);
  logic [7:0] left = 8'h00;
  assign por_release_out = supply_on_in;
  // Pin is always driven, so no released level has to be modelled
  assign pin_b_out = (left == 8'h00);
  always @(posedge clk_in) begin
    if (pulse_in) begin
      left <= low_len_in;
    end else if (left != 8'h00) begin
      left <= left - 8'h01;
    end
  end
endmodule : supply_pin_model
`default_nettype wire

// >>> verification/testbench.sv
// Self-checking bench for the system reset sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin \
  checked++; \
  if ((g) !== (e)) begin \
    errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); \
  end \
end
module testbench;
  import rst_seq_pkg::*;
  // Short counts keep the run brief; expectations follow these values
  localparam int unsigned POR_N = 40;
  localparam int unsigned PIN_N = 4;
  localparam int unsigned LIMIT = 3000;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic supply_on = 1'b1;
  logic pin_go = 1'b0;
  logic [7:0] pin_len = 8'h0A;
  logic [3:0] warm = 4'h0;
  logic xosc_req = 1'b0;
  logic pll_req = 1'b0;
  logic flags_clr = 1'b0;
  logic sec_wr = 1'b0;
  logic sec_d = 1'b0;
  logic clk_en = 1'b1;
  logic por_rel, pin_b, sys_b, cold_b, iosc, xosc, pll, sec;
  reset_sources_t flags;
  int unsigned errors = 0, checked = 0, cycles = 0, n;
  logic [31:0] lfsr = 32'h2582;
  logic [1:0] k;
  always #5 clk = ~clk;
  supply_pin_model model_u (.clk_in(clk), .supply_on_in(supply_on), .pulse_in(pin_go), .low_len_in(pin_len),
    .por_release_out(por_rel), .pin_b_out(pin_b));
  system_reset_sequencer #(.POR_COUNT_CYCLES(POR_N), .PIN_MIN_CYCLES(PIN_N)) dut_u (
    .REF_CLK_IN(clk), .RST_B_IN(rst_b), .CLK_EN_IN(clk_en), .POR_RELEASE_IN(por_rel),
    .VOLTAGE_DROP_DETECTOR_IN(warm[3]), .RESET_PIN_B_IN(pin_b), .WATCHDOG_TIMER_IN(warm[2]),
    .OSC_FREQUENCY_DETECTOR_IN(warm[1]), .SOFTWARE_RESET_REQUEST_IN(warm[0]),
    .XOSC_ENABLE_REQ_IN(xosc_req), .PLL_ENABLE_REQ_IN(pll_req), .FLAGS_CLEAR_IN(flags_clr),
    .FLASH_SEC_WRITE_IN(sec_wr), .FLASH_SEC_DATA_IN(sec_d), .SYS_RESET_B_OUT(sys_b),
    .COLD_RESET_B_OUT(cold_b), .IOSC_ENABLE_OUT(iosc), .XOSC_ENABLE_OUT(xosc), .PLL_ENABLE_OUT(pll),
    .RESET_SOURCE_FLAGS_OUT(flags), .FLASH_SECURITY_BIT_REG_OUT(sec));

  function automatic logic [31:0] nxt(input logic [31:0] l);
    return {l[30:0], 1'b0} ^ (l[31] ? 32'h04C11DB7 : 32'h00000000);
  endfunction : nxt

  function automatic reset_sources_t exp_flag(input int unsigned pos);
    return reset_sources_t'(6'h01 << pos);
  endfunction : exp_flag

  // Warm inputs 0..3 are software, frequency, watchdog and voltage drop
  function automatic int unsigned warm_pos(input logic [1:0] i);
    return (i == 2'h3) ? FLAG_POS_VOLTAGE_DROP : int'(i);
  endfunction : warm_pos

  task automatic test_done();
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done

  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick

  // Counts edges to release; the pin and a security write are tried meanwhile
  task automatic count_release();
    n = 0;
    sec_d = 1'b1;
    while (sys_b !== 1'b1 && n < POR_N + 10) begin
      pin_go = (n == 5);
      sec_wr = (n == 10);
      tick();
      n++;
      if (n == 20) `CHK(xosc, 1'b0)
    end
    pin_go = 1'b0;
    sec_wr = 1'b0;
    `CHK(n, POR_N + 1)
    `CHK(flags, exp_flag(FLAG_POS_POR))
    `CHK(cold_b, 1'b1)
    `CHK(sec, FLASH_SEC_RESET)
    tick();
    `CHK(xosc, 1'b1)
    `CHK(pll, 1'b1)
  endtask : count_release

  task automatic pin_pulse(input logic [7:0] len, input logic hit);
    logic seen;
    seen = 1'b0;
    pin_len = len;
    pin_go = 1'b1;
    tick();
    pin_go = 1'b0;
    repeat (len + 3) begin
      tick();
      if (sys_b === 1'b0) seen = 1'b1;
    end
    tick();
    `CHK(seen, hit)
    `CHK(sys_b, 1'b1)
    if (hit) `CHK(flags, exp_flag(FLAG_POS_PIN))
  endtask : pin_pulse

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      errors++;
      test_done();
    end
  end

  initial begin
    repeat (20) tick();
    `CHK(sys_b, 1'b0)
    `CHK(cold_b, 1'b0)
    `CHK(iosc, 1'b1)
    `CHK(flags, FLAGS_RESET)
    xosc_req = 1'b1;
    pll_req = 1'b1;
    rst_b = 1'b1;
    count_release();
    sec_d = 1'b1;
    sec_wr = 1'b1;
    tick();
    sec_wr = 1'b0;
    `CHK(sec, 1'b1)
    for (int i = 0; i < 10; i++) begin
      lfsr = nxt(lfsr);
      k = (i < 4) ? i[1:0] : lfsr[1:0];
      warm[k] = 1'b1;
      tick();
      warm[k] = 1'b0;
      `CHK(sys_b, 1'b0)
      `CHK(flags, exp_flag(warm_pos(k)))
      `CHK(cold_b, 1'b1)
      `CHK(sec, 1'b1)
      `CHK(xosc, 1'b0)
      tick();
      `CHK(sys_b, 1'b1)
    end
    flags_clr = 1'b1;
    tick();
    flags_clr = 1'b0;
    `CHK(flags, FLAGS_RESET)
    // Frozen enable: a source waits for it; a new cause beats a clear
    clk_en = 1'b0;
    warm[2] = 1'b1;
    repeat (3) tick();
    `CHK(sys_b, 1'b1)
    clk_en = 1'b1;
    flags_clr = 1'b1;
    tick();
    flags_clr = 1'b0;
    `CHK(flags, exp_flag(FLAG_POS_WATCHDOG))
    tick();
    warm[2] = 1'b0;
    `CHK(sys_b, 1'b0)
    tick();
    `CHK(sys_b, 1'b1)
    xosc_req = 1'b0;
    pll_req = 1'b0;
    tick();
    `CHK(xosc, 1'b0)
    `CHK(pll, 1'b0)
    xosc_req = 1'b1;
    pll_req = 1'b1;
    pin_pulse(8'(PIN_N - 1), 1'b0);
    repeat (3) begin
      lfsr = nxt(lfsr);
      pin_pulse(8'(PIN_N + 1) + {5'h00, lfsr[2:0]}, 1'b1);
    end
    `CHK(sec, 1'b1)
    supply_on = 1'b0;
    repeat (3) tick();
    `CHK(cold_b, 1'b0)
    `CHK(sys_b, 1'b0)
    supply_on = 1'b1;
    count_release();
    sec_wr = 1'b1;
    tick();
    sec_wr = 1'b0;
    `CHK(sec, 1'b1)
    rst_b = 1'b0;
    tick();
    `CHK(sys_b, 1'b0)
    `CHK(cold_b, 1'b0)
    `CHK(sec, FLASH_SEC_RESET)
    `CHK(flags, FLAGS_RESET)
    rst_b = 1'b1;
    count_release();
    test_done();
  end
endmodule : testbench
`default_nettype wire
